// ==== rtl/clk_warmup_pkg.sv ====
// constants shared by the clock selector, divider chain and warm-up counter
// assumes a byte-wide register port and synchronous single-cycle tick inputs
package clk_warmup_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_SYS_CTRL1 = 3'h0;   // system_control_one
  localparam logic [2:0] OFS_SYS_CTRL2 = 3'h1;   // system_control_two
  localparam logic [2:0] OFS_WU_CTRL   = 3'h2;   // warmup_control
  localparam logic [2:0] OFS_WU_CMP    = 3'h3;   // warmup_compare_value
  localparam logic [2:0] OFS_STATUS    = 3'h4;   // clock and warm-up status

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned BIT_DIV9_SEL = 4;      // system_control_one
  localparam int unsigned BIT_IHF_EN   = 7;      // system_control_two
  localparam int unsigned BIT_EHF_EN   = 6;
  localparam int unsigned BIT_LF_EN    = 5;
  localparam int unsigned BIT_SRC_SEL  = 4;
  localparam int unsigned WU_SEL_LSB   = 0;      // warmup_control, 2 bits
  localparam int unsigned WU_DIV_LSB   = 2;      // warmup_control, 2 bits
  localparam int unsigned BIT_WU_ABORT = 4;
  localparam int unsigned ST_ACTIVE    = 0;      // status bits
  localparam int unsigned ST_PENDING   = 1;
  localparam int unsigned ST_SOFT_BUSY = 2;
  localparam int unsigned ST_RUN       = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and encodings
  localparam logic [7:0] RST_WU_CMP = 8'h66;
  localparam logic [1:0] RST_WU_SEL = 2'h0;
  localparam logic [1:0] RST_WU_DIV = 2'h3;
  localparam logic       RST_IHF_EN = 1'b1;
  localparam logic [1:0] SRC_IHF    = 2'h0;
  localparam logic [1:0] SRC_EHF    = 2'h1;
  localparam logic [1:0] SRC_LF     = 2'h2;

  // timing counts: divider stages, counter bits, and ticks of the new source
  localparam int unsigned LOW_STAGES        = 8;   // divider stages 1..8
  localparam int unsigned LF_QUARTER_W      = 2;   // low_freq_clock / 4
  localparam int unsigned SWITCH_SYNC_TICKS = 2;   // new-source ticks before switch

  typedef enum logic [2:0] {WU_POR, WU_IDLE, WU_SOFT, WU_HALT, WU_WAKE} wu_state_e;

endpackage

// ==== rtl/clk_warmup_ctrl.sv ====
// main system clock selector, prescaler/divider chain and warm-up counter
// clocks are modelled as one-cycle tick inputs on SYS_CLK_IN; the cpu core
// consumes FM_TICK_OUT, RUN_OUT and the reset outputs
`timescale 1ns/100ps

module clk_warmup_ctrl
#(
  parameter int unsigned DIV_W    = 21,
  parameter int unsigned WU_CNT_W = 14,
  parameter int unsigned PRESC_W  = 2
)
(
  input  wire logic                                SYS_CLK_IN,
  input  wire logic                                RST_N_IN,
  input  wire logic [clk_warmup_pkg::ADDR_W-1:0]   ADDR_IN,
  input  wire logic [clk_warmup_pkg::DATA_W-1:0]   WDATA_IN,
  input  wire logic                                WR_IN,
  input  wire logic                                RD_IN,
  input  wire logic                                GEAR_TICK_IN,
  input  wire logic                                LF_TICK_IN,
  input  wire logic                                IHF_TICK_IN,
  input  wire logic                                EHF_TICK_IN,
  input  wire logic                                STOP_ENTER_IN,
  input  wire logic                                STOP_RELEASE_IN,
  output logic      [clk_warmup_pkg::DATA_W-1:0]   RDATA_OUT,
  output logic                                     FM_TICK_OUT,
  output logic      [DIV_W-1:0]                    DIV_TAPS_OUT,
  output logic      [2:0]                          OSC_EN_OUT,
  output logic                                     CPU_RST_N_OUT,
  output logic                                     RUN_OUT,
  output logic                                     SYSCLK_RST_OUT,
  output logic                                     WARMUP_DONE_INT_OUT
);

  localparam int unsigned LOW = clk_warmup_pkg::LOW_STAGES;
  localparam int unsigned CW  = clk_warmup_pkg::DATA_W;

  // refuse geometries the compare window or stage split cannot serve
  generate
    if (DIV_W <= LOW || WU_CNT_W < CW || PRESC_W < 1)
    begin : g_bad_params
      $error("clk_warmup_ctrl: unsupported parameter values");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic                         div9_sel_ff;
  logic                         src_sel_ff;
  logic                         ihf_en_ff;
  logic                         ehf_en_ff;
  logic                         lf_en_ff;
  logic [1:0]                   wu_sel_ff;
  logic [1:0]                   wu_div_ff;
  logic                         abort_ff;
  logic [CW-1:0]                cmp_ff;
  logic                         active_ff;
  logic [1:0]                   sw_cnt_ff;
  logic [clk_warmup_pkg::LF_QUARTER_W-1:0] lf_q_ff;
  logic [PRESC_W-1:0]           presc_ff;
  logic [DIV_W-1:0]             div_ff;
  logic [WU_CNT_W-1:0]          wu_cnt_ff;
  logic [2:0]                   pre_ff;
  logic [1:0]                   stop_src_ff;
  clk_warmup_pkg::wu_state_e    wu_state_ff;
  clk_warmup_pkg::wu_state_e    nxt_wu_state;

  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_wuctl;
  logic osc_rise;

  assign wr_ctrl1 = WR_IN && ADDR_IN == clk_warmup_pkg::OFS_SYS_CTRL1;
  assign wr_ctrl2 = WR_IN && ADDR_IN == clk_warmup_pkg::OFS_SYS_CTRL2;
  assign wr_wuctl = WR_IN && ADDR_IN == clk_warmup_pkg::OFS_WU_CTRL;

  // only a 0-to-1 change of an enable starts warm-up
  assign osc_rise = wr_ctrl2 && (
    (WDATA_IN[clk_warmup_pkg::BIT_IHF_EN] && !ihf_en_ff) ||
    (WDATA_IN[clk_warmup_pkg::BIT_EHF_EN] && !ehf_en_ff) ||
    (WDATA_IN[clk_warmup_pkg::BIT_LF_EN]  && !lf_en_ff));

  // system control registers, software-owned
  // reset values of selection and compare
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      div9_sel_ff <= 1'b0;
      src_sel_ff  <= 1'b0;
      ihf_en_ff   <= clk_warmup_pkg::RST_IHF_EN;
      ehf_en_ff   <= 1'b0;
      lf_en_ff    <= 1'b0;
      wu_sel_ff   <= clk_warmup_pkg::RST_WU_SEL;
      wu_div_ff   <= clk_warmup_pkg::RST_WU_DIV;
      cmp_ff      <= clk_warmup_pkg::RST_WU_CMP;
    end
    else
    begin
      if (wr_ctrl1)
        div9_sel_ff <= WDATA_IN[clk_warmup_pkg::BIT_DIV9_SEL];
      if (wr_ctrl2)
      begin
        ihf_en_ff  <= WDATA_IN[clk_warmup_pkg::BIT_IHF_EN];
        ehf_en_ff  <= WDATA_IN[clk_warmup_pkg::BIT_EHF_EN];
        lf_en_ff   <= WDATA_IN[clk_warmup_pkg::BIT_LF_EN];
        src_sel_ff <= WDATA_IN[clk_warmup_pkg::BIT_SRC_SEL];
      end
      if (wr_wuctl)
      begin
        wu_sel_ff <= WDATA_IN[clk_warmup_pkg::WU_SEL_LSB +: 2];
        wu_div_ff <= WDATA_IN[clk_warmup_pkg::WU_DIV_LSB +: 2];
      end
      if (WR_IN && ADDR_IN == clk_warmup_pkg::OFS_WU_CMP)
        cmp_ff <= WDATA_IN;
    end
  end

  // abort is latched for one cycle, acts, then reads back as 0
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      abort_ff <= 1'b0;
    else
      abort_ff <= wr_wuctl && WDATA_IN[clk_warmup_pkg::BIT_WU_ABORT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // main system clock selection
  logic fs4_tick;
  logic new_tick;
  logic pend;
  logic old_dead;
  logic viol;

  assign fs4_tick = LF_TICK_IN && (&lf_q_ff);
  assign pend     = src_sel_ff != active_ff;
  assign new_tick = active_ff ? GEAR_TICK_IN : fs4_tick;
  assign old_dead = active_ff ? !lf_en_ff : !(ihf_en_ff || ehf_en_ff);
  // old oscillator stopped while switch still pending
  assign viol     = pend && old_dead;

  // quarter of the low-frequency clock
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      lf_q_ff <= '0;
    else if (LF_TICK_IN)
      lf_q_ff <= lf_q_ff + 1'b1;
  end

  // switch only after the new source ticked twice, at a tick boundary
  // so neither source is cut short; a violation forces the switch at once
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      active_ff <= 1'b0;
      sw_cnt_ff <= 2'h0;
    end
    else if (!pend)
      sw_cnt_ff <= 2'h0;
    else if (viol || (new_tick &&
             sw_cnt_ff == 2'(clk_warmup_pkg::SWITCH_SYNC_TICKS - 1)))
    begin
      active_ff <= src_sel_ff;
      sw_cnt_ff <= 2'h0;
    end
    else if (new_tick)
      sw_cnt_ff <= sw_cnt_ff + 2'h1;
  end

  // one main clock tick is one machine cycle
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      FM_TICK_OUT <= 1'b0;
    else
      FM_TICK_OUT <= active_ff ? fs4_tick : GEAR_TICK_IN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and divider chain
  logic lo_en;
  logic lo_carry;
  logic hi_en;
  logic clear_chain;
  logic match;

  // low stages run only while the gear clock is selected
  assign lo_en    = !src_sel_ff && GEAR_TICK_IN && (&presc_ff);
  assign lo_carry = lo_en && (&div_ff[LOW-1:0]);
  assign hi_en    = (div9_sel_ff || src_sel_ff) ? fs4_tick : lo_carry;
  // wake warm-up end restarts the chain from zero
  assign clear_chain = wu_state_ff == clk_warmup_pkg::WU_WAKE && match;

  // chain clear on reset and after stop warm-up
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN || clear_chain)
    begin
      presc_ff <= '0;
      div_ff   <= '0;
    end
    else
    begin
      if (!src_sel_ff && GEAR_TICK_IN)
        presc_ff <= presc_ff + 1'b1;
      if (lo_en)
        div_ff[LOW-1:0] <= div_ff[LOW-1:0] + 1'b1;
      if (hi_en)
        div_ff[DIV_W-1:LOW] <= div_ff[DIV_W-1:LOW] + 1'b1;
    end
  end

  assign DIV_TAPS_OUT = div_ff;
  assign OSC_EN_OUT   = {ihf_en_ff, ehf_en_ff, lf_en_ff};

  ////////////////////////////////////////////////////////////////////////////
  // warm-up counter: source select, 3-stage divider, counter
  // source code to tick; stop wake and soft/power-on paths share it
  function automatic logic pick_tick(input logic [1:0] code, input logic ihf,
                                     input logic ehf, input logic lf);
    pick_tick = (code == clk_warmup_pkg::SRC_IHF) ? ihf :
                (code == clk_warmup_pkg::SRC_EHF) ? ehf :
                (code == clk_warmup_pkg::SRC_LF)  ? lf  : 1'b0;
  endfunction

  logic       counting;
  logic       src_tick;
  logic       div_tick;
  logic [2:0] div_mask;

  assign counting = wu_state_ff == clk_warmup_pkg::WU_POR ||
                    wu_state_ff == clk_warmup_pkg::WU_SOFT ||
                    wu_state_ff == clk_warmup_pkg::WU_WAKE;
  // wake uses the clock captured at stop entry
  assign src_tick = pick_tick(wu_state_ff == clk_warmup_pkg::WU_WAKE ? stop_src_ff
                              : wu_sel_ff, IHF_TICK_IN, EHF_TICK_IN, LF_TICK_IN);
  // division by 1, 2, 4 or 8
  assign div_mask = 3'((4'h1 << wu_div_ff) - 4'h1);
  assign div_tick = counting && src_tick && ((pre_ff & div_mask) == div_mask);
  // upper eight counter bits against the compare value
  assign match    = counting && wu_cnt_ff[WU_CNT_W-1 -: CW] == cmp_ff;

  // warm-up sequencing
  always_comb
  begin
    nxt_wu_state = wu_state_ff;
    unique case (wu_state_ff)
      clk_warmup_pkg::WU_POR:
        if (match)
          nxt_wu_state = clk_warmup_pkg::WU_IDLE;
      clk_warmup_pkg::WU_IDLE:
        if (STOP_ENTER_IN)
          nxt_wu_state = clk_warmup_pkg::WU_HALT;
        else if (osc_rise)
          nxt_wu_state = clk_warmup_pkg::WU_SOFT;
      clk_warmup_pkg::WU_SOFT:
        if (match || abort_ff)
          nxt_wu_state = clk_warmup_pkg::WU_IDLE;
        else if (STOP_ENTER_IN)
          nxt_wu_state = clk_warmup_pkg::WU_HALT;
      clk_warmup_pkg::WU_HALT:
        if (STOP_RELEASE_IN)
          nxt_wu_state = clk_warmup_pkg::WU_WAKE;
      clk_warmup_pkg::WU_WAKE:
        if (match)
          nxt_wu_state = clk_warmup_pkg::WU_IDLE;
      default:
        nxt_wu_state = clk_warmup_pkg::WU_IDLE;
    endcase
  end

  // power-on warm-up starts right after reset
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      wu_state_ff <= clk_warmup_pkg::WU_POR;
    else
      wu_state_ff <= nxt_wu_state;
  end

  // remember which clock drove the main clock at stop entry
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      stop_src_ff <= clk_warmup_pkg::SRC_IHF;
    else if (STOP_ENTER_IN && (wu_state_ff == clk_warmup_pkg::WU_IDLE ||
                               wu_state_ff == clk_warmup_pkg::WU_SOFT))
      stop_src_ff <= active_ff ? clk_warmup_pkg::SRC_LF :
                     ihf_en_ff ? clk_warmup_pkg::SRC_IHF : clk_warmup_pkg::SRC_EHF;
  end

  // match or abort clears; a stop simply freezes the count
  // which is why a stop taken mid soft warm-up gives a short wake-up
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN || match ||
        (abort_ff && wu_state_ff == clk_warmup_pkg::WU_SOFT))
    begin
      wu_cnt_ff <= '0;
      pre_ff    <= 3'h0;
    end
    else if (counting && src_tick)
    begin
      pre_ff <= pre_ff + 3'h1;
      if (div_tick)
        wu_cnt_ff <= wu_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset, run and event outputs
  // cpu reset held through power-on warm-up and on a violation
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      CPU_RST_N_OUT       <= 1'b0;
      SYSCLK_RST_OUT      <= 1'b0;
      RUN_OUT             <= 1'b0;
      WARMUP_DONE_INT_OUT <= 1'b0;
    end
    else
    begin
      CPU_RST_N_OUT       <= nxt_wu_state != clk_warmup_pkg::WU_POR && !viol;
      SYSCLK_RST_OUT      <= viol;
      RUN_OUT             <= nxt_wu_state == clk_warmup_pkg::WU_IDLE ||
                             nxt_wu_state == clk_warmup_pkg::WU_SOFT;
      WARMUP_DONE_INT_OUT <= wu_state_ff == clk_warmup_pkg::WU_SOFT && match;
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN || !RD_IN)
      RDATA_OUT <= '0;
    else
      unique case (ADDR_IN)
        clk_warmup_pkg::OFS_SYS_CTRL1:
          RDATA_OUT <= CW'({div9_sel_ff, 4'h0});
        clk_warmup_pkg::OFS_SYS_CTRL2:
          RDATA_OUT <= {ihf_en_ff, ehf_en_ff, lf_en_ff, src_sel_ff, 4'h0};
        clk_warmup_pkg::OFS_WU_CTRL:
          RDATA_OUT <= CW'({wu_div_ff, wu_sel_ff});
        clk_warmup_pkg::OFS_WU_CMP:
          RDATA_OUT <= cmp_ff;
        clk_warmup_pkg::OFS_STATUS:
          RDATA_OUT <= CW'({RUN_OUT, wu_state_ff == clk_warmup_pkg::WU_SOFT,
                            pend, active_ff});
        default:
          RDATA_OUT <= '0;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence soft_match_s;
    wu_state_ff == clk_warmup_pkg::WU_SOFT && match;
  endsequence

  sequence wake_done_s;
    wu_state_ff == clk_warmup_pkg::WU_WAKE ##0 match;
  endsequence

  fm_source_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    FM_TICK_OUT |-> $past(active_ff ? fs4_tick : GEAR_TICK_IN))
    else $error("main clock tick not from selected source");

  switch_sync_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $changed(active_ff) |-> $past(viol) || ($past(new_tick) &&
      $past(sw_cnt_ff) == 2'(clk_warmup_pkg::SWITCH_SYNC_TICKS - 1)))
    else $error("clock switch without synchronisation");

  low_stop_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    src_sel_ff && !clear_chain |=> $stable(DIV_TAPS_OUT[LOW-1:0]))
    else $error("low divider stages ran with low-frequency source");

  stage_nine_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (div9_sel_ff || src_sel_ff) && !fs4_tick && !clear_chain
      |=> $stable(DIV_TAPS_OUT[DIV_W-1:LOW]))
    else $error("stage nine advanced without lf quarter tick");

  viol_reset_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    viol |=> SYSCLK_RST_OUT && !CPU_RST_N_OUT ##1 !SYSCLK_RST_OUT)
    else $error("clock violation did not pulse system reset");

  por_hold_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    $rose(CPU_RST_N_OUT) |-> $past(match) || $past(SYSCLK_RST_OUT))
    else $error("cpu reset released before warm-up match");

  soft_done_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    soft_match_s |=> WARMUP_DONE_INT_OUT && wu_cnt_ff == '0 && RUN_OUT)
    else $error("soft warm-up end not signalled");

  abort_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    abort_ff && wu_state_ff == clk_warmup_pkg::WU_SOFT
      |=> wu_cnt_ff == '0 && !abort_ff && wu_state_ff == clk_warmup_pkg::WU_IDLE)
    else $error("abort did not stop and clear warm-up");

  halt_hold_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wu_state_ff == clk_warmup_pkg::WU_HALT |=> $stable(wu_cnt_ff))
    else $error("warm-up count moved during stop");

  wake_clear_a : assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wake_done_s |=> DIV_TAPS_OUT == '0 && RUN_OUT)
    else $error("chain not cleared after stop warm-up");

endmodule

// ==== tb/osc_tick_model.sv ====
// oscillator model: turns the block's oscillator enables into tick streams
// assumes one clock; a stopped oscillator gives no ticks at all
`timescale 1ns/100ps

module osc_tick_model
(
  input  wire logic       clk_in,
  input  wire logic [2:0] osc_en_in,
  input  wire logic       gear_rnd_in,
  input  wire logic       lf_rnd_in,
  output logic            gear_tick_out,
  output logic            lf_tick_out,
  output logic            ihf_tick_out,
  output logic            ehf_tick_out
);

  //////////////////////////////////////////////////////////////////////////
  // only the lf and gear ticks are irregular
  // hf ticks every cycle so warm-up lengths are exact; lf and gear jitter
  always_ff @(posedge clk_in)
  begin
    ihf_tick_out  <= osc_en_in[2];
    ehf_tick_out  <= osc_en_in[1];
    lf_tick_out   <= osc_en_in[0] & lf_rnd_in;
    gear_tick_out <= (osc_en_in[2] | osc_en_in[1]) & gear_rnd_in;
  end

endmodule

// ==== tb/test_clk_warmup_ctrl.sv ====
// self-checking bench for the clock selector and warm-up counter
// assumes the oscillator model drives all tick inputs
`timescale 1ns/100ps

module test_clk_warmup_ctrl;

  logic        sys_clk;
  logic        rst_n;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        stop_enter;
  logic        stop_release;
  logic        gear_rnd;
  logic        lf_rnd;
  logic        gear_t;
  logic        lf_t;
  logic        ihf_t;
  logic        ehf_t;
  logic [7:0]  rdata;
  logic        fm_t;
  logic [20:0] taps;
  logic [2:0]  osc_en;
  logic        cpu_rst_n;
  logic        run;
  logic        sysclk_rst;
  logic        wu_int;
  logic [7:0]  v;
  logic [20:0] taps0;
  int          fails;
  int          n_checks;
  int          n;
  int          nf;
  int          nl;
  int          seed;
  int          exp_cmp;
  int          mdl[4];
  int          wmask[4];

  clk_warmup_ctrl i_dut (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .GEAR_TICK_IN(gear_t), .LF_TICK_IN(lf_t),
    .IHF_TICK_IN(ihf_t), .EHF_TICK_IN(ehf_t), .STOP_ENTER_IN(stop_enter),
    .STOP_RELEASE_IN(stop_release), .RDATA_OUT(rdata), .FM_TICK_OUT(fm_t),
    .DIV_TAPS_OUT(taps), .OSC_EN_OUT(osc_en), .CPU_RST_N_OUT(cpu_rst_n), .RUN_OUT(run),
    .SYSCLK_RST_OUT(sysclk_rst), .WARMUP_DONE_INT_OUT(wu_int));

  osc_tick_model i_osc (.clk_in(sys_clk), .osc_en_in(osc_en), .gear_rnd_in(gear_rnd),
    .lf_rnd_in(lf_rnd), .gear_tick_out(gear_t), .lf_tick_out(lf_t),
    .ihf_tick_out(ihf_t), .ehf_tick_out(ehf_t));

  //////////////////////////////////////////////////////////////////////////
  // clock and random jitter for the oscillator model
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    gear_rnd <= $random(seed);
    lf_rnd   <= $random(seed);
  end

  //////////////////////////////////////////////////////////////////////////
  // shared bus, wait and compare tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    // register image: only writable bits stick, abort reads back 0
    if (a < 3'h4)
      mdl[a] = d & wmask[a];
  endtask

  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 d = rdata;
    if (a < 3'h4)
      check(d, mdl[a]);
  endtask

  // sel 0 cpu reset, 1 interrupt, 2 clock reset, 3 run
  function automatic logic pick(input int sel);
    pick = (sel == 0) ? cpu_rst_n : (sel == 1) ? wu_int : (sel == 2) ? sysclk_rst : run;
  endfunction

  // watch every cycle, so a one-cycle pulse cannot slip past
  task count_hi(input int sel, input int lim, output int hits);
    hits = 0;
    repeat (lim)
    begin
      @(posedge sys_clk);
      #1 hits += (pick(sel) === 1'b1);
    end
  endtask

  // bounded wait for the selected output to go high
  task wait_hi(input int sel, input int lim, output int cnt);
    logic s;
    cnt = 0;
    s   = 1'b0;
    while (s !== 1'b1 && cnt < lim)
    begin
      @(posedge sys_clk);
      #1 cnt++;
      s = pick(sel);
    end
    if (s !== 1'b1)
    begin
      fails++;
      finish_test();
    end
  endtask

  task count_ticks(output int f, output int l);
    f = 0;
    l = 0;
    repeat (120)
    begin
      @(posedge sys_clk);
      #1 f += fm_t;
      l += lf_t;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h1e8e;
    {rst_n, addr, wdata, wr, rd, stop_enter, stop_release, gear_rnd, lf_rnd} = '0;
    fails = 0;
    n_checks = 0;
    exp_cmp = 8'h66;
    mdl   = '{8'h00, 8'h80, 8'h0c, 8'h66};
    wmask = '{8'h10, 8'hf0, 8'h0f, 8'hff};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd_reg(3'h3, v);
    check(v, exp_cmp);
    rd_reg(3'h2, v);
    check(v, 8'h0c);
    rd_reg(3'h1, v);
    check(v[7], 1'b1);
    rd_reg(3'h5, v);
    check(v, 8'h00);
    check(cpu_rst_n, 1'b0);
    check(osc_en, 3'b100);
    $display("test reset values done");
    // power-on warm-up: 0x66 * 2^9 ihf ticks before cpu reset lifts
    wait_hi(0, 60000, n);
    n += 8;
    check(n >= 52224 && n <= 52234, 1'b1);
    check(run, 1'b1);
    $display("test power-on warm-up done");
    // gear clock drives machine cycles
    count_ticks(nf, nl);
    check(nf > 20, 1'b1);
    // soft warm-up on ehf, div 1, compare 1: 2^6 ticks
    exp_cmp = 8'h01;
    wr_reg(3'h3, exp_cmp[7:0]);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h1, 8'hc0);
    wait_hi(1, 200, n);
    check(n >= 60 && n <= 70, 1'b1);
    wr_reg(3'h1, 8'hc0);
    count_hi(1, 150, n);
    check(n, 0);
    rd_reg(3'h4, v);
    check(v[2], 1'b0);
    $display("test soft warm-up done");
    // abort mid warm-up; enables stay
    wr_reg(3'h1, 8'h80);
    wr_reg(3'h1, 8'hc0);
    repeat (10) @(posedge sys_clk);
    wr_reg(3'h2, 8'h11);
    count_hi(1, 150, n);
    check(n, 0);
    rd_reg(3'h2, v);
    check(v, 8'h01);
    check(osc_en, 3'b110);
    $display("test abort done");
    // stop with ehf off and source field on ehf: wake must count ihf
    wr_reg(3'h1, 8'h80);
    @(posedge sys_clk);
    stop_enter <= 1'b1;
    @(posedge sys_clk);
    stop_enter <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(run, 1'b0);
    @(posedge sys_clk);
    stop_release <= 1'b1;
    @(posedge sys_clk);
    stop_release <= 1'b0;
    wait_hi(3, 200, n);
    check(n >= 60 && n <= 70, 1'b1);
    check(taps < 21'h4, 1'b1);
    $display("test stop wake done");
    // stop taken mid soft warm-up: wake resumes from the held count, so short
    wr_reg(3'h1, 8'hc0);
    repeat (20) @(posedge sys_clk);
    stop_enter <= 1'b1;
    @(posedge sys_clk);
    stop_enter <= 1'b0;
    @(posedge sys_clk);
    stop_release <= 1'b1;
    @(posedge sys_clk);
    stop_release <= 1'b0;
    wait_hi(3, 200, n);
    check(n >= 40 && n <= 50, 1'b1);
    $display("test stop in soft warm-up done");
    // switch to lf/4 after its own warm-up
    wr_reg(3'h2, 8'h02);
    wr_reg(3'h1, 8'ha0);
    wait_hi(1, 400, n);
    wr_reg(3'h1, 8'hb0);
    repeat (60) @(posedge sys_clk);
    rd_reg(3'h4, v);
    check(v[0], 1'b1);
    taps0 = taps;
    count_ticks(nf, nl);
    check(taps[7:0], taps0[7:0]);
    check(taps[20:8] !== taps0[20:8], 1'b1);
    check((nf - nl / 4) * (nf - nl / 4) <= 1, 1'b1);
    $display("test lf switch done");
    // back to gear with lf stopped while pending
    wr_reg(3'h1, 8'h80);
    wait_hi(2, 10, n);
    check(sysclk_rst, 1'b1);
    $display("test clock reset done");
    finish_test();
  end

endmodule
